// ==== logic/fpsm_setup_menu.sv ====
// Front-panel setup menu: key chord detection, screen sequencing,
// digit editing and the stored settings, with a simple register port.
// Assumes keys are active high and synchronous to clk.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module fpsm_setup_menu import fpsm_pkg::*; #(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned WIN_CYC = CHORD_CYC,
  parameter int unsigned BLK_CYC = BLINK_CYC,
  parameter int unsigned COMM_CYC = COMM_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic keyFuncRaw,
  input wire logic keyConfirmRaw,
  input wire logic commQuery,
  input wire logic commResp,
  input wire logic [3:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [15:0] busRdata,
  output logic setIndicator,
  output logic [1:0] commIcons,
  output logic [8:0] screenSel,
  output logic editActive,
  output logic [2:0] cursorPos,
  output logic cursorLit,
  output logic [19:0] editDigits,
  output logic [2:0] optValue,
  output logic energyWipe,
  output logic [2:0] lampLevel,
  output logic [15:0] ratedCurrent,
  output logic [6:0] shuntMv,
  output logic curRangeSel,
  output logic voltRangeSel
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Order of parameter screens after the passcode
  function automatic fpsm_scr_t nextScr(fpsm_scr_t s, logic ind);
    unique case (s)
      SCR_RATED: nextScr = SCR_SHUNT;
      SCR_SHUNT: nextScr = SCR_CUR_RNG;
      SCR_CUR_RNG: nextScr = SCR_VOLT_RNG;
      SCR_VOLT_RNG: nextScr = SCR_WIPE;
      SCR_WIPE: nextScr = SCR_LAMP;
      SCR_LAMP: nextScr = SCR_PASS_SET;
      default: nextScr = ind ? SCR_RATED : SCR_SHUNT;
    endcase
  endfunction

  function automatic logic [16:0] bcdToBin(logic [19:0] d);
    bcdToBin = 17'(d[19:16]) * 17'h02710 + 17'(d[15:12]) * 17'h003E8
      + 17'(d[11:8]) * 17'h00064 + 17'(d[7:4]) * 17'h0000A + 17'(d[3:0]);
  endfunction

  function automatic logic [19:0] binToBcd(logic [15:0] v);
    logic [15:0] r;
    binToBcd = '0;
    r = v;
    for (int i = 0; i < 5; i++) begin
      binToBcd[4*i +: 4] = 4'(r % 16'h000A);
      r = r / 16'h000A;
    end
  endfunction

  // ---------------------------------------------------------------
  // Key debounce and chord detection
  // ---------------------------------------------------------------
  logic [1:0] keyRaw;
  logic [1:0] keyLvl;
  assign keyRaw = {keyConfirmRaw, keyFuncRaw};

  genvar gk;
  generate
    for (gk = 0; gk < 2; gk++) begin : gDeb
      fpsm_key_debounce #(.CYC(DEB_CYC)) uDeb (
        .clk(clk),
        .rstn(rstn),
        .rawIn(keyRaw[gk]),
        .stable(keyLvl[gk])
      );
    end
  endgenerate

  localparam int unsigned WW = $clog2(WIN_CYC + 1);
  fpsm_key_t key_q;
  logic [WW-1:0] win_q;
  logic firstF_q;
  logic evF_q, evC_q, evChord_q;
  wire anyKey = |keyLvl;
  wire bothKey = &keyLvl;
  wire winEnd = (win_q == WW'(WIN_CYC - 1));

  // A lone key acts on release or window expiry, so a chord never
  // leaks a single-key action first; costs a short reaction delay.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      key_q <= KEY_IDLE;
      win_q <= '0;
      firstF_q <= 1'b0;
      evF_q <= 1'b0;
      evC_q <= 1'b0;
      evChord_q <= 1'b0;
    end else begin
      evF_q <= 1'b0;
      evC_q <= 1'b0;
      evChord_q <= 1'b0;
      unique case (key_q)
        KEY_IDLE: if (anyKey) begin
          key_q <= KEY_WAIT;
          win_q <= '0;
          firstF_q <= keyLvl[0];
        end
        KEY_WAIT: if (bothKey) begin
          evChord_q <= 1'b1;
          key_q <= KEY_HOLD;
        end else if (!anyKey || winEnd) begin
          evF_q <= firstF_q;
          evC_q <= !firstF_q;
          key_q <= anyKey ? KEY_HOLD : KEY_IDLE;
        end else begin
          win_q <= win_q + 1'b1;
        end
        KEY_HOLD: if (!anyKey) begin
          key_q <= KEY_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Menu state and stored settings
  // ---------------------------------------------------------------
  fpsm_scr_t scr_q;
  logic setInd_q, edit_q, wipe_q, indirect_q;
  logic curRng_q, voltRng_q;
  logic [2:0] cur_q, opt_q, lamp_q;
  logic [19:0] digs_q;
  logic [15:0] rated_q, pass_q;
  logic [6:0] shunt_q;

  // Decode of the digit under the cursor and the commit candidate
  wire [3:0] digNow = digs_q[{cur_q, 2'b00} +: 4];
  wire [3:0] digInc = (digNow == 4'h9) ? 4'h0 : digNow + 4'h1;
  wire [16:0] editVal = bcdToBin(digs_q);
  wire ratedOk = (editVal >= 17'(RATED_MIN)) && (editVal <= 17'(RATED_MAX));
  wire shuntOk = (editVal >= 17'(SHUNT_MIN)) && (editVal <= 17'(SHUNT_MAX));
  wire fpsm_scr_t nextS = nextScr(scr_q, indirect_q);
  wire [2:0] optNext = (nextS == SCR_CUR_RNG) ? {2'b00, curRng_q} :
                       (nextS == SCR_VOLT_RNG) ? {2'b00, voltRng_q} :
                       (nextS == SCR_LAMP) ? lamp_q : 3'h0;
  wire [2:0] lampInc = (opt_q >= LAMP_MAX) ? LAMP_MIN : opt_q + 3'h1;
  wire [2:0] curTop = (scr_q == SCR_RATED) ? CUR_TOP_RATED :
                      (scr_q == SCR_SHUNT) ? CUR_TOP_SHUNT : CUR_TOP_PASS;
  wire numScr = (scr_q == SCR_RATED) || (scr_q == SCR_SHUNT) || (scr_q == SCR_PASS_SET);
  wire [15:0] loadVal = (scr_q == SCR_RATED) ? rated_q :
                        (scr_q == SCR_SHUNT) ? {9'h000, shunt_q} : 16'h0000;
  wire [19:0] loadDigs = (scr_q == SCR_PASS_SET) ? {4'h0, pass_q} : binToBcd(loadVal);
  logic [19:0] digsInc;

  always_comb begin
    digsInc = digs_q;
    digsInc[{cur_q, 2'b00} +: 4] = digInc;
  end

  // Key events drive the screen walk; chord has priority over all
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scr_q <= SCR_METER;
      setInd_q <= 1'b0;
      edit_q <= 1'b0;
      cur_q <= 3'h0;
      opt_q <= 3'h0;
      digs_q <= '0;
      wipe_q <= 1'b0;
      rated_q <= RATED_RST;
      shunt_q <= SHUNT_RST;
      pass_q <= PASS_RST;
      curRng_q <= RANGE_RST;
      voltRng_q <= RANGE_RST;
      lamp_q <= LAMP_RST;
    end else begin
      wipe_q <= 1'b0;
      if (evChord_q && scr_q == SCR_METER) begin
        scr_q <= SCR_PASS_IN;
        setInd_q <= 1'b1;
        edit_q <= 1'b1;
        cur_q <= CUR_TOP_PASS;
        digs_q <= '0;
      end else if (evChord_q) begin
        scr_q <= SCR_METER;
        setInd_q <= 1'b0;
        edit_q <= 1'b0;
      end else if (evF_q && edit_q) begin
        digs_q <= digsInc;
      end else if (evC_q && edit_q && cur_q != 3'h0) begin
        cur_q <= cur_q - 3'h1;
      end else if (evC_q && edit_q) begin
        edit_q <= 1'b0;
        unique case (scr_q)
          SCR_PASS_IN: if (digs_q[15:0] == pass_q) begin
            scr_q <= nextS;
            opt_q <= optNext;
          end else begin
            scr_q <= SCR_METER;
            setInd_q <= 1'b0;
          end
          SCR_RATED: if (ratedOk) begin
            rated_q <= editVal[15:0];
          end
          SCR_SHUNT: begin
            if (shuntOk) begin
              shunt_q <= editVal[6:0];
            end
            scr_q <= nextS;
            opt_q <= optNext;
          end
          default: pass_q <= digs_q[15:0];
        endcase
      end else if (evF_q && numScr) begin
        edit_q <= 1'b1;
        cur_q <= curTop;
        digs_q <= loadDigs;
      end else if (evF_q && scr_q != SCR_METER) begin
        opt_q <= (scr_q == SCR_LAMP) ? lampInc : {2'b00, !opt_q[0]};
      end else if (evC_q && scr_q != SCR_METER) begin
        scr_q <= nextS;
        opt_q <= optNext;
        unique case (scr_q)
          SCR_CUR_RNG: curRng_q <= opt_q[0];
          SCR_VOLT_RNG: voltRng_q <= opt_q[0];
          SCR_WIPE: wipe_q <= opt_q[0];
          SCR_LAMP: lamp_q <= opt_q;
          default: lamp_q <= lamp_q;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Cursor flash and communication icons
  // ---------------------------------------------------------------
  localparam int unsigned BW = $clog2(BLK_CYC + 1);
  localparam int unsigned CCW = $clog2(COMM_CYC + 1);
  logic [BW-1:0] blk_q;
  logic blink_q, lit_q;
  logic [CCW-1:0] idle_q;
  logic [1:0] icons_q;

  // Flash runs free; phase is not aligned to the edit start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blk_q <= '0;
      blink_q <= 1'b0;
      lit_q <= 1'b0;
    end else begin
      blk_q <= (blk_q == BW'(BLK_CYC - 1)) ? '0 : blk_q + 1'b1;
      if (blk_q == BW'(BLK_CYC - 1)) begin
        blink_q <= !blink_q;
      end
      lit_q <= edit_q && blink_q;
    end
  end

  // Icons fall back to none after a quiet spell on the line
  always_ff @(posedge clk) begin
    if (!rstn) begin
      icons_q <= 2'h0;
      idle_q <= '0;
    end else if (commResp && icons_q != 2'h0) begin
      icons_q <= 2'h2;
      idle_q <= '0;
    end else if (commQuery) begin
      icons_q <= 2'h1;
      idle_q <= '0;
    end else if (idle_q == CCW'(COMM_CYC - 1)) begin
      icons_q <= 2'h0;
    end else begin
      idle_q <= idle_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  logic [15:0] rd_q;
  wire [15:0] rdMux =
    (busAddr == OFS_CTRL) ? {15'h0000, indirect_q} :
    (busAddr == OFS_STATUS) ? {scr_q, cur_q, edit_q, icons_q, setInd_q} :
    (busAddr == OFS_RATED) ? rated_q :
    (busAddr == OFS_SHUNT) ? {9'h000, shunt_q} :
    (busAddr == OFS_OPTS) ? {11'h000, lamp_q, voltRng_q, curRng_q} :
    (busAddr == OFS_PASS) ? pass_q : 16'h0000;

  // Read data lives one cycle only; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_q <= 16'h0000;
      indirect_q <= CTRL_INDIRECT_RST;
    end else begin
      rd_q <= busRd ? rdMux : 16'h0000;
      if (busWr && busAddr == OFS_CTRL) begin
        indirect_q <= busWdata[0];
      end
    end
  end

  assign busRdata = rd_q;
  assign setIndicator = setInd_q;
  assign commIcons = icons_q;
  assign screenSel = scr_q;
  assign editActive = edit_q;
  assign cursorPos = cur_q;
  assign cursorLit = lit_q;
  assign editDigits = digs_q;
  assign optValue = opt_q;
  assign energyWipe = wipe_q;
  assign lampLevel = lamp_q;
  assign ratedCurrent = rated_q;
  assign shuntMv = shunt_q;
  assign curRangeSel = curRng_q;
  assign voltRangeSel = voltRng_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_CHORD_ENTER: assert property (
    evChord_q && scr_q == SCR_METER |=> scr_q == SCR_PASS_IN && setInd_q && edit_q)
    else $error("chord in metering did not open passcode");
  AST_CHORD_EXIT: assert property (
    evChord_q && scr_q != SCR_METER |=> scr_q == SCR_METER && !edit_q)
    else $error("chord in setting did not return to metering");
  AST_SET_IND: assert property (
    setInd_q == (scr_q != SCR_METER))
    else $error("setting indicator disagrees with mode");
  AST_COMM_TWO: assert property (
    commResp && icons_q != 2'h0 ##1 !commQuery |-> icons_q == 2'h2 [*2])
    else $error("response did not show two icons");
  AST_DIG_INC: assert property (
    evF_q && edit_q && !evChord_q && digNow == 4'h9 |=> digNow == 4'h0)
    else $error("digit did not wrap to zero");
  AST_RATED_RANGE: assert property (
    rated_q >= RATED_MIN && rated_q <= RATED_MAX)
    else $error("rated current out of range");
  AST_SHUNT_RANGE: assert property (
    shunt_q >= SHUNT_MIN && shunt_q <= SHUNT_MAX)
    else $error("shunt output out of range");
  AST_SKIP_RATED: assert property (
    $rose(scr_q == SCR_RATED) |-> indirect_q)
    else $error("rated screen shown with direct wiring");
  AST_SHUNT_ADV: assert property (
    evC_q && edit_q && cur_q == 3'h0 && scr_q == SCR_SHUNT
    |=> scr_q == SCR_CUR_RNG && !edit_q)
    else $error("shunt commit did not advance");
  AST_LAMP_RANGE: assert property (
    lamp_q >= LAMP_MIN && lamp_q <= LAMP_MAX)
    else $error("lamp level out of range");
  AST_WIPE_SRC: assert property (
    wipe_q |-> $past(scr_q) == SCR_WIPE && $past(opt_q[0]))
    else $error("energy wipe without Yes confirmed");
  AST_KEY_EXCL: assert property (
    evChord_q |-> !evF_q && !evC_q ##1 !evChord_q)
    else $error("chord and single key events overlap");

  COV_ENTER: cover property (evChord_q && scr_q == SCR_METER);
  COV_PASS_OK: cover property ($past(scr_q) == SCR_PASS_IN && scr_q != SCR_METER);
  COV_RATED: cover property ($changed(rated_q));
  COV_WIPE: cover property (wipe_q);

endmodule
`default_nettype wire

// ==== logic/fpsm_pkg.sv ====
// Constants, screen codes and register map of the front-panel setup menu.
// Assumes a single 20 MHz clock and a synchronous active-low reset.
// Function
// - Both keys in metering enter setting mode
// - Both keys in setting mode return to metering
// - Setting indicator lit while in setting mode
// - Comm icons: none, query sent, response received
// - Passcode screen precedes parameter screens
// - Stored passcode resets to all zeros
// - Confirm on passcode screen enters parameter screens
// - Confirm commits or advances to next screen
// - Function key changes setting or starts editing
// - Function key increments flashing digit
// - Confirm moves cursor to next digit
// - Confirm on last digit commits, stops flashing
// - Confirm steps screens up to rated current
// - Rated current limited to 20..50000 A
// - Rated current screen only with indirect wiring
// - Shunt output limited to 50..100 mV
// - Shunt commit on last digit advances screen
// - Current sensor range code defaults zero
// - Voltage sensor range code defaults zero
// - Energy wipe defaults No, Yes clears energy
// - Five backlight levels, one dimmest
package fpsm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned CHORD_MS = 100;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned COMM_HOLD_MS = 1000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned CHORD_CYC = CHORD_MS * CLK_KHZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int unsigned COMM_HOLD_CYC = COMM_HOLD_MS * CLK_KHZ;

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_RATED = 4'h2;
  localparam logic [3:0] OFS_SHUNT = 4'h3;
  localparam logic [3:0] OFS_OPTS = 4'h4;
  localparam logic [3:0] OFS_PASS = 4'h5;
  localparam logic CTRL_INDIRECT_RST = 1'h1;
  localparam logic [15:0] RATED_RST = 16'h0014;
  localparam logic [15:0] RATED_MIN = 16'h0014;
  localparam logic [15:0] RATED_MAX = 16'hC350;
  localparam logic [6:0] SHUNT_RST = 7'h64;
  localparam logic [6:0] SHUNT_MIN = 7'h32;
  localparam logic [6:0] SHUNT_MAX = 7'h64;
  localparam logic [15:0] PASS_RST = 16'h0000;
  localparam logic RANGE_RST = 1'h0;
  localparam logic [2:0] LAMP_MIN = 3'h1;
  localparam logic [2:0] LAMP_MAX = 3'h5;
  localparam logic [2:0] LAMP_RST = 3'h5;

  // ---------------------------------------------------------------
  // Cursor start positions (digit 0 is the last one)
  // ---------------------------------------------------------------
  localparam logic [2:0] CUR_TOP_RATED = 3'h4;
  localparam logic [2:0] CUR_TOP_SHUNT = 3'h2;
  localparam logic [2:0] CUR_TOP_PASS = 3'h3;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    SCR_METER = 9'h001,
    SCR_PASS_IN = 9'h002,
    SCR_RATED = 9'h004,
    SCR_SHUNT = 9'h008,
    SCR_CUR_RNG = 9'h010,
    SCR_VOLT_RNG = 9'h020,
    SCR_WIPE = 9'h040,
    SCR_LAMP = 9'h080,
    SCR_PASS_SET = 9'h100
  } fpsm_scr_t;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'h1,
    KEY_WAIT = 3'h2,
    KEY_HOLD = 3'h4
  } fpsm_key_t;

endpackage

// ==== logic/fpsm_key_debounce.sv ====
// Debouncer for one front-panel key.
// Assumes the raw key level is already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module fpsm_key_debounce #(
  parameter int unsigned CYC = 200000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rawIn,
  output logic stable
);
  localparam int unsigned CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_q;
  logic stable_q;

  // Level must hold for CYC cycles before it is believed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      stable_q <= 1'b0;
    end else if (rawIn == stable_q) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(CYC - 1)) begin
      cnt_q <= '0;
      stable_q <= rawIn;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign stable = stable_q;
endmodule
`default_nettype wire

// ==== tb/fpsm_testbench.sv ====
// Self-checking testbench for the front-panel setup menu.
// Assumes shortened debounce, window, blink and comm-hold counts.
`timescale 1ns/10ps
`default_nettype none
module testbench import fpsm_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic keyFuncRaw = 1'b0;
  logic keyConfirmRaw = 1'b0;
  logic commQuery = 1'b0;
  logic commResp = 1'b0;
  logic [3:0] busAddr = 4'h0;
  logic [15:0] busWdata = 16'h0000;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [15:0] busRdata;
  logic setIndicator;
  logic [1:0] commIcons;
  logic [8:0] screenSel;
  logic editActive;
  logic [2:0] cursorPos;
  logic cursorLit;
  logic [19:0] editDigits;
  logic [2:0] optValue;
  logic energyWipe;
  logic [2:0] lampLevel;
  logic [15:0] ratedCurrent;
  logic [6:0] shuntMv;
  logic curRangeSel;
  logic voltRangeSel;
  logic wipeSeen = 1'b0;
  logic [15:0] rdat;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  fpsm_setup_menu #(.DEB_CYC(4), .WIN_CYC(16), .BLK_CYC(8), .COMM_CYC(32)) fpsm_setup_menu_i (
    .clk(clk), .rstn(rstn), .keyFuncRaw(keyFuncRaw), .keyConfirmRaw(keyConfirmRaw),
    .commQuery(commQuery), .commResp(commResp), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .setIndicator(setIndicator),
    .commIcons(commIcons), .screenSel(screenSel), .editActive(editActive),
    .cursorPos(cursorPos), .cursorLit(cursorLit), .editDigits(editDigits),
    .optValue(optValue), .energyWipe(energyWipe), .lampLevel(lampLevel),
    .ratedCurrent(ratedCurrent), .shuntMv(shuntMv), .curRangeSel(curRangeSel),
    .voltRangeSel(voltRangeSel));

  // 20 MHz clock; hang guard counts cycles well past the expected run
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    wipeSeen <= wipeSeen | (energyWipe === 1'b1);
    if (cycles == 12000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Held well past debounce but inside the chord window, so one event each
  task automatic key(input logic f, input logic c, input int n);
    repeat (n) begin
      @(posedge clk);
      keyFuncRaw <= f;
      keyConfirmRaw <= c;
      repeat (10) @(posedge clk);
      keyFuncRaw <= 1'b0;
      keyConfirmRaw <= 1'b0;
      repeat (24) @(posedge clk);
    end
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge clk);
    busWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'b0;
    #1 d = busRdata;
  endtask

  task automatic comm(input logic q);
    @(posedge clk);
    commQuery <= q;
    commResp <= ~q;
    @(posedge clk);
    commQuery <= 1'b0;
    commResp <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic login(input int inc);
    key(1'b1, 1'b1, 1);
    key(1'b1, 1'b0, inc);
    key(1'b0, 1'b1, 4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(20'(screenSel), 20'h00001, "screen");
    chk(20'(setIndicator), 20'h0, "set ind");
    chk(20'(lampLevel), 20'h5, "lamp");
    chk(20'(ratedCurrent), 20'h00014, "rated");
    chk(20'(shuntMv), 20'h64, "shunt");
    chk(20'({voltRangeSel, curRangeSel}), 20'h0, "ranges");
    rd(4'h5, rdat);
    chk(20'(rdat), 20'h0, "pass reg");
    rd(4'h4, rdat);
    chk(20'(rdat), 20'h14, "opts reg");
    rd(4'hF, rdat);
    chk(20'(rdat), 20'h0, "unmapped");
  endtask

  task automatic t_comm;
    comm(1'b0);
    chk(20'(commIcons), 20'h0, "resp alone");
    comm(1'b1);
    chk(20'(commIcons), 20'h1, "query");
    comm(1'b0);
    chk(20'(commIcons), 20'h2, "response");
    repeat (40) @(posedge clk);
    #1 chk(20'(commIcons), 20'h0, "idle");
  endtask

  task automatic t_badpass;
    login(1);
    chk(20'(screenSel), 20'h00001, "bad code");
    chk(20'(setIndicator), 20'h0, "bad ind");
  endtask

  task automatic t_enter;
    logic lit;
    lit = 1'b0;
    key(1'b1, 1'b1, 1);
    chk(20'(screenSel), 20'h00002, "pass scr");
    chk(20'(setIndicator), 20'h1, "set on");
    chk(20'({editActive, cursorPos}), 20'hB, "pass edit");
    chk(editDigits, 20'h00000, "pass digits");
    rd(4'h1, rdat);
    chk(20'(rdat), 20'h00139, "status");
    repeat (20) begin
      @(posedge clk);
      #1 lit = lit | (cursorLit === 1'b1);
    end
    chk(20'(lit), 20'h1, "blink");
    key(1'b0, 1'b1, 3);
    chk(20'(cursorPos), 20'h0, "cursor");
    key(1'b0, 1'b1, 1);
    chk(20'(screenSel), 20'h00004, "rated scr");
  endtask

  task automatic t_rated;
    key(1'b1, 1'b0, 1);
    chk(20'({editActive, cursorPos}), 20'hC, "rated edit");
    chk(editDigits, 20'h00020, "rated load");
    key(1'b0, 1'b1, 2);
    key(1'b1, 1'b0, 1);
    chk(editDigits, 20'h00120, "inc");
    key(1'b0, 1'b1, 1);
    key(1'b1, 1'b0, 8);
    chk(editDigits, 20'h00100, "wrap");
    key(1'b0, 1'b1, 2);
    chk(20'(ratedCurrent), 20'h00064, "commit");
    chk(20'({editActive, screenSel}), 20'h004, "stop");
    chk(20'(cursorLit), 20'h0, "no flash");
    key(1'b1, 1'b0, 1);
    key(1'b0, 1'b1, 2);
    key(1'b1, 1'b0, 9);
    key(1'b0, 1'b1, 3);
    chk(20'(ratedCurrent), 20'h00064, "reject");
    wr(4'h2, 16'h1234);
    rd(4'h2, rdat);
    chk(20'(rdat), 20'h00064, "rated ro");
    key(1'b0, 1'b1, 1);
    chk(20'(screenSel), 20'h00008, "next");
  endtask

  task automatic t_shunt;
    key(1'b1, 1'b0, 1);
    chk(editDigits, 20'h00100, "shunt load");
    chk(20'(cursorPos), 20'h2, "shunt cur");
    key(1'b1, 1'b0, 9);
    key(1'b0, 1'b1, 1);
    key(1'b1, 1'b0, 5);
    chk(editDigits, 20'h00050, "shunt dig");
    key(1'b0, 1'b1, 2);
    chk(20'(shuntMv), 20'h32, "shunt");
    rd(4'h3, rdat);
    chk(20'(rdat), 20'h00032, "shunt reg");
    chk(20'(screenSel), 20'h00010, "shunt adv");
  endtask

  task automatic t_opts;
    key(1'b1, 1'b0, 1);
    chk(20'(optValue), 20'h1, "opt");
    key(1'b0, 1'b1, 1);
    chk(20'({curRangeSel, screenSel}), 20'h220, "cur rng");
    key(1'b1, 1'b0, 1);
    key(1'b0, 1'b1, 1);
    chk(20'({voltRangeSel, screenSel}), 20'h240, "volt rng");
    chk(20'(optValue[0]), 20'h0, "wipe no");
    chk(20'(wipeSeen), 20'h0, "no wipe yet");
    key(1'b1, 1'b0, 1);
    key(1'b0, 1'b1, 1);
    chk(20'(wipeSeen), 20'h1, "wipe");
    key(1'b1, 1'b0, 1);
    key(1'b0, 1'b1, 1);
    chk(20'(lampLevel), 20'h1, "lamp");
    chk(20'(screenSel), 20'h00100, "pass set");
  endtask

  task automatic t_passset;
    key(1'b1, 1'b0, 2);
    key(1'b0, 1'b1, 4);
    rd(4'h5, rdat);
    chk(20'(rdat), 20'h01000, "new code");
    key(1'b0, 1'b1, 1);
    chk(20'(screenSel), 20'h00004, "wrap scr");
    key(1'b1, 1'b1, 1);
    chk(20'({setIndicator, screenSel}), 20'h001, "exit");
  endtask

  task automatic t_direct;
    wr(4'h0, 16'h0000);
    rd(4'h0, rdat);
    chk(20'(rdat), 20'h0, "ctrl");
    login(1);
    chk(20'({setIndicator, screenSel}), 20'h208, "skip rated");
    key(1'b1, 1'b1, 1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_comm();
    t_badpass();
    t_enter();
    t_rated();
    t_shunt();
    t_opts();
    t_passset();
    t_direct();
    tally_and_finish();
  end
endmodule
`default_nettype wire
